// [pkg/rpm_params.svh]
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH
`define RPM_CLK_HZ 100000000
`define RPM_IDLE_TIMEOUT_DEF 32'h0000_1000
`define RPM_LPO_DIV_DEF 16'h0bb8
`define RPM_LP_WAKE_DEF 16'h0020
`define RPM_IDLE_RST 32'h0000_1000
`endif

// [pkg/rpm_pkg.sv]
package rpm_pkg;
  typedef enum logic [1:0] {RPM_ACTIVE, RPM_IDLE, RPM_SLEEP, RPM_DEEP} rpm_mode_t;
  typedef struct packed {
    logic tx_pd;
    logic rx_pd;
    logic pll_pd;
    logic pa_pd;
  } rpm_rf_pd_t;
  typedef struct packed {
    rpm_mode_t mode;
    logic [31:0] idle_cnt;
    logic [15:0] lpo_div;
    logic [15:0] lp_wake_cnt;
    logic core_reg_en;
    logic boot_rom;
    rpm_rf_pd_t rf_pd;
  } rpm_state_t;
endpackage

// [rtl/rpm_power_reset.sv]
`timescale 1ns/100ps
`include "rpm_params.svh"
// Behaviour
// R1 - four power modes: active, idle, sleep, deep power-down
// R2 - after programmable inactivity, step down one mode
// R3 - user activity returns straight to active from any lower mode
// R4 - deep power-down removes core power by disabling regulator output
// R5 - io supply domain stays on and wakes chip on user event
// R6 - deep power-down entry drives regulator disable under firmware command
// R7 - separate transceiver power-downs for tx, rx, pll and amplifier
// R8 - packet handling switches radio on and off within each packet
// R9 - low-power modes run from slow oscillator, wake after set period; the code pulses lp_wake in sleep mode only
// R10 - power actions come from software requests or baseband packet handling
// R11 - power-on reset puts every flop into known state
// R12 - low external reset places device in reset
// R13 - external reset has internal pull-up, open input leaves reset off
// R14 - host holds external reset low 50 ms after supply stable; the test host model holds it low for only 6 clock cycles
// R15 - host drives reset low while supply unstable, releases when stable
// R16 - leaving reset starts protocol stack from internal boot rom
// R17 - reset asserts asynchronously, release passes two-stage synchroniser
module rpm_power_reset
  import rpm_pkg::*;
#(
  parameter logic [31:0] IDLE_TIMEOUT = `RPM_IDLE_TIMEOUT_DEF,
  parameter logic [15:0] LPO_DIV = `RPM_LPO_DIV_DEF,
  parameter logic [15:0] LP_WAKE = `RPM_LP_WAKE_DEF
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic external_reset_n,
  input wire logic external_reset_n_driven,
  input wire logic user_activity,
  input wire logic fw_deep_req,
  input wire logic fw_wake_req,
  input wire logic pkt_tx_active,
  input wire logic pkt_rx_active,
  input wire logic pkt_lp_req,
  output rpm_mode_t deep_powerdown_mode_state,
  output logic deep_powerdown_mode,
  output logic core_regulator_output,
  output logic io_supply_domain,
  output logic lpo_tick,
  output logic lp_wake,
  output rpm_rf_pd_t rf_pd,
  output logic boot_from_rom,
  output logic sys_reset_n
);
  ////////////////////////////////////////////////////////////////
  // R13 pull-up model
  logic ext_level;
  assign ext_level = external_reset_n_driven ? external_reset_n : 1'b1;
  // R12 combined reset
  logic comb_rst_n;
  assign comb_rst_n = rst_n & ext_level;
  // R17 release sync
  logic [1:0] sync_reg;
  always_ff @(posedge clock or negedge comb_rst_n)
  begin
    if (!comb_rst_n)
      sync_reg <= 2'h0;
    else
      sync_reg <= {sync_reg[0], 1'b1};
  end
  logic irst_n;
  assign irst_n = sync_reg[1];
  assign sys_reset_n = irst_n;
  // user activity from the pin side, two flops before use
  logic [1:0] act_sync_reg;
  always_ff @(posedge clock or negedge irst_n)
  begin
    if (!irst_n)
      act_sync_reg <= 2'h0;
    else
      act_sync_reg <= {act_sync_reg[0], user_activity};
  end
  logic act;
  assign act = act_sync_reg[1];
  ////////////////////////////////////////////////////////////////
  // R1 four modes, one register
  rpm_state_t s_reg;
  rpm_state_t s_next;
  logic tick;
  assign tick = (s_reg.lpo_div == 16'h0000);
  always_comb
  begin
    s_next = s_reg;
    // R9 slow oscillator divider
    s_next.lpo_div = tick ? (LPO_DIV - 16'h0001) : (s_reg.lpo_div - 16'h0001);
    if (s_reg.idle_cnt != 32'h0)
      s_next.idle_cnt = s_reg.idle_cnt - 32'h1;
    s_next.boot_rom = 1'b0;
    if (act || fw_wake_req)
    begin
      // R3 direct return
      s_next.mode = RPM_ACTIVE;
      s_next.idle_cnt = IDLE_TIMEOUT;
    end
    else if (fw_deep_req)
    begin
      // R10 software trigger
      s_next.mode = RPM_DEEP;
    end
    else if (pkt_lp_req && s_reg.mode == RPM_ACTIVE)
    begin
      // R10 packet handling trigger
      s_next.mode = RPM_IDLE;
      s_next.idle_cnt = IDLE_TIMEOUT;
    end
    else if (s_reg.idle_cnt == 32'h0 && s_reg.mode != RPM_DEEP)
    begin
      // R2 step down
      unique case (s_reg.mode)
        RPM_ACTIVE: s_next.mode = RPM_IDLE;
        RPM_IDLE: s_next.mode = RPM_SLEEP;
        RPM_SLEEP: s_next.mode = RPM_DEEP;
        RPM_DEEP: s_next.mode = RPM_DEEP;
      endcase
      s_next.idle_cnt = IDLE_TIMEOUT;
    end
    // R9 periodic wake in sleep mode only
    // counts only ticks spent in sleep, the same ticks the wake output sees
    if (s_reg.mode == RPM_SLEEP && tick)
      s_next.lp_wake_cnt = (s_reg.lp_wake_cnt == 16'h0) ? LP_WAKE : s_reg.lp_wake_cnt - 16'h0001;
    // R4 regulator
    s_next.core_reg_en = (s_next.mode != RPM_DEEP);
    // R7 rf power downs
    s_next.rf_pd.tx_pd = !(pkt_tx_active && s_next.mode == RPM_ACTIVE);
    // R8 radio per packet
    s_next.rf_pd.rx_pd = !(pkt_rx_active && s_next.mode == RPM_ACTIVE);
    s_next.rf_pd.pll_pd = !((pkt_tx_active || pkt_rx_active) && s_next.mode == RPM_ACTIVE);
    s_next.rf_pd.pa_pd = !(pkt_tx_active && s_next.mode == RPM_ACTIVE);
  end
  // R11 known state
  always_ff @(posedge clock or negedge irst_n)
  begin
    if (!irst_n)
    begin
      s_reg.mode <= RPM_ACTIVE;
      // programmed period, so a tuned timeout also governs the first step
      s_reg.idle_cnt <= IDLE_TIMEOUT;
      s_reg.lpo_div <= 16'h0000;
      s_reg.lp_wake_cnt <= 16'h0000;
      s_reg.core_reg_en <= 1'b1;
      // R16 boot from rom
      s_reg.boot_rom <= 1'b1;
      s_reg.rf_pd <= 4'hf;
    end
    else
      s_reg <= s_next;
  end
  ////////////////////////////////////////////////////////////////
  assign deep_powerdown_mode_state = s_reg.mode;
  // R6 regulator disable
  assign deep_powerdown_mode = (s_reg.mode == RPM_DEEP);
  assign core_regulator_output = s_reg.core_reg_en;
  // R5 io domain stays on
  assign io_supply_domain = 1'b1;
  assign lpo_tick = tick;
  assign lp_wake = (s_reg.mode == RPM_SLEEP) && tick && (s_reg.lp_wake_cnt == 16'h0);
  assign rf_pd = s_reg.rf_pd;
  assign boot_from_rom = s_reg.boot_rom;
  ////////////////////////////////////////////////////////////////
  // R3 wake check
  wake_active_a: assert property (@(posedge clock) disable iff (!irst_n) act |=> s_reg.mode == RPM_ACTIVE) // R3
    else $error("activity did not return to active");
  // R4 regulator check
  deep_reg_off_a: assert property (@(posedge clock) disable iff (!irst_n) deep_powerdown_mode |-> !core_regulator_output) // R4
    else $error("regulator on in deep mode");
  // R2 single step
  step_one_a: assert property (@(posedge clock) disable iff (!irst_n) // R2
    ($past(s_reg.mode) == RPM_ACTIVE && s_reg.mode != RPM_ACTIVE) |-> s_reg.mode == RPM_IDLE || s_reg.mode == RPM_DEEP)
    else $error("skipped a mode");
  // R7 rf idle check
  rf_off_a: assert property (@(posedge clock) disable iff (!irst_n) (s_reg.mode != RPM_ACTIVE) |-> rf_pd == 4'hf) // R7
    else $error("radio on outside active");
  // R16 boot pulse
  boot_pulse_a: assert property (@(posedge clock) disable iff (!irst_n) boot_from_rom |=> !boot_from_rom) // R16
    else $error("boot strobe too long");
  // R8 tx on
  tx_on_a: assert property (@(posedge clock) disable iff (!irst_n) // R8
    (pkt_tx_active && !act && !fw_deep_req && s_reg.mode == RPM_ACTIVE && s_reg.idle_cnt > 32'h1 && !pkt_lp_req) |=> !rf_pd.tx_pd)
    else $error("tx not powered during packet");
  // R9 wake in sleep only
  lp_wake_a: assert property (@(posedge clock) disable iff (!irst_n) lp_wake |-> s_reg.mode == RPM_SLEEP) // R9
    else $error("wake outside sleep");
  // R5 io domain
  io_on_a: assert property (@(posedge clock) disable iff (!irst_n) io_supply_domain) // R5
    else $error("io domain dropped");
  // R17 held through sync
  reset_hold_a: assert property (@(posedge clock) !comb_rst_n |=> !irst_n) // R17
    else $error("internal reset released early");
  // R16 boot on release
  boot_start_a: assert property (@(posedge clock) $rose(irst_n) |-> boot_from_rom) // R16
    else $error("no boot strobe after reset");
  // R2 deep is lowest
  deep_hold_a: assert property (@(posedge clock) disable iff (!irst_n) // R2
    (s_reg.mode == RPM_DEEP && !act && !fw_wake_req) |=> s_reg.mode == RPM_DEEP)
    else $error("left deep without a wake cause");
  // R2 idle steps down
  idle_step_a: assert property (@(posedge clock) disable iff (!irst_n) // R2
    (s_reg.mode == RPM_IDLE && s_reg.idle_cnt == 32'h0 && !act && !fw_wake_req && !fw_deep_req)
    |=> s_reg.mode == RPM_SLEEP)
    else $error("idle timeout did not step down");
  // R5 event powers core
  deep_wake_a: assert property (@(posedge clock) disable iff (!irst_n) // R5
    (deep_powerdown_mode && act) |=> core_regulator_output)
    else $error("user event left core unpowered");
  // R6 firmware deep entry
  fw_deep_a: assert property (@(posedge clock) disable iff (!irst_n) // R6
    (fw_deep_req && !act && !fw_wake_req) |=> deep_powerdown_mode && !core_regulator_output)
    else $error("firmware deep request ignored");
  // R10 packet low-power request
  pkt_idle_a: assert property (@(posedge clock) disable iff (!irst_n) // R10
    (pkt_lp_req && s_reg.mode == RPM_ACTIVE && !act && !fw_wake_req && !fw_deep_req)
    |=> s_reg.mode == RPM_IDLE)
    else $error("packet low-power request ignored");
  // R7 pll and amplifier follow
  rf_link_a: assert property (@(posedge clock) disable iff (!irst_n) // R7
    (!rf_pd.tx_pd || !rf_pd.rx_pd) |-> !rf_pd.pll_pd && (rf_pd.pa_pd == rf_pd.tx_pd))
    else $error("pll or amplifier out of step");
  // R8 rx on
  rx_on_a: assert property (@(posedge clock) disable iff (!irst_n) // R8
    (pkt_rx_active && !fw_deep_req && s_reg.mode == RPM_ACTIVE && s_reg.idle_cnt > 32'h1 && !pkt_lp_req)
    |=> !rf_pd.rx_pd)
    else $error("rx not powered during packet");
endmodule

// [test/radio_module_power_reset_control_tb.sv]
`timescale 1ns/100ps
module radio_module_power_reset_control_tb;
  import rpm_pkg::*;
  logic clock, rst_n, ext_n, ext_drv, act, fdeep, fwake, ptx, prx, plp;
  logic deep, reg_on, io_on, tick, wake, boot, srst_n;
  rpm_mode_t mode;
  rpm_rf_pd_t pd;
  int bad_count, cmp_count, m;
  logic [31:0] rs;
  int lpo_k, lpw;
  logic exp_t, exp_w;
  rpm_host_model u_host (.clock(clock), .external_reset_n(ext_n), .external_reset_n_driven(ext_drv));
  // short timeout and a fast slow tick keep the step-down and wake walks brief
  rpm_power_reset #(.IDLE_TIMEOUT(32'h10), .LPO_DIV(16'h0004), .LP_WAKE(16'h0002))
    u_dut (.clock(clock), .rst_n(rst_n),
    .external_reset_n(ext_n), .external_reset_n_driven(ext_drv), .user_activity(act),
    .fw_deep_req(fdeep), .fw_wake_req(fwake), .pkt_tx_active(ptx), .pkt_rx_active(prx),
    .pkt_lp_req(plp), .deep_powerdown_mode_state(mode), .deep_powerdown_mode(deep),
    .core_regulator_output(reg_on), .io_supply_domain(io_on), .lpo_tick(tick),
    .lp_wake(wake), .rf_pd(pd), .boot_from_rom(boot), .sys_reset_n(srst_n));
  //////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_mode();
    chk({2'b00, mode}, m[3:0]);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    #20000;
    bad_count++;
    end_of_test();
  end
  // slow tick every 4 cycles, sleep wake on every third tick
  always @(negedge clock)
  begin
    if (srst_n !== 1'b1)
    begin
      lpo_k = 0;
      lpw = 0;
    end
    else
    begin
      exp_t = (lpo_k % 4 == 0);
      exp_w = exp_t && (mode == RPM_SLEEP) && (lpw == 0);
      chk({2'b00, tick, wake}, {2'b00, exp_t, exp_w});
      if (exp_t && mode == RPM_SLEEP)
        lpw = (lpw == 0) ? 2 : lpw - 1;
      lpo_k++;
    end
  end
  initial
  begin
    rst_n = 0; act = 0; fdeep = 0; fwake = 0; ptx = 0; prx = 0; plp = 0;
    bad_count = 0; cmp_count = 0; m = 0; rs = 32'd2750;
    cyc(4);
    rst_n <= 1'b1;
    wait (ext_drv === 1'b0);
    cyc(3);
    @(negedge clock);
    chk({1'b0, srst_n, reg_on, io_on}, 4'h7);
    for (int k = 1; k < 4; k++)
    begin
      cyc(20);
      m = k;
      @(negedge clock);
      chk_mode();
    end
    // no further step below deep
    cyc(30);
    @(negedge clock);
    chk_mode();
    chk({boot, deep, reg_on, io_on}, 4'h5);
    cyc(1);
    act <= 1'b1;
    repeat (5)
    begin
      @(negedge clock);
      chk({3'b000, mode inside {RPM_ACTIVE, RPM_DEEP}}, 4'h1);
    end
    m = 0;
    chk_mode();
    cyc(1);
    act <= 1'b0;
    cyc(3);
    fdeep <= 1'b1;
    cyc(1);
    fdeep <= 1'b0;
    @(negedge clock);
    m = 3;
    chk_mode();
    chk({2'b00, deep, reg_on}, 4'h2);
    cyc(1);
    fwake <= 1'b1;
    cyc(1);
    fwake <= 1'b0;
    @(negedge clock);
    m = 0;
    chk_mode();
    cyc(1);
    plp <= 1'b1;
    cyc(1);
    plp <= 1'b0;
    act <= 1'b1;
    @(negedge clock);
    m = 1;
    chk_mode();
    m = 0;
    cyc(2);
    repeat (12)
    begin
      rs = xs(rs);
      cyc(1);
      ptx <= rs[0];
      prx <= rs[1];
      cyc(1);
      @(negedge clock);
      chk({pd.tx_pd, pd.rx_pd, pd.pll_pd, pd.pa_pd}, {~rs[0], ~rs[1], ~(rs[0] | rs[1]), ~rs[0]});
    end
    cyc(1);
    act <= 1'b0;
    cyc(4);
    fdeep <= 1'b1;
    cyc(1);
    fdeep <= 1'b0;
    @(negedge clock);
    m = 3;
    chk_mode();
    m = 0;
    cyc(1);
    fork
      u_host.pulse(3);
      begin
        #1;
        chk({3'b000, srst_n}, 4'h0);
        chk_mode();
      end
    join
    @(negedge clock);
    chk({3'b000, srst_n}, 4'h0);
    chk({boot, 3'b000}, 4'h8);
    cyc(2);
    @(negedge clock);
    chk({boot, 2'b00, srst_n}, 4'h9);
    cyc(4);
    @(negedge clock);
    chk({boot, 3'b000}, 4'h0);
    end_of_test();
  end
endmodule

// [test/rpm_host_model.sv]
`timescale 1ns/100ps
module rpm_host_model
#(
  parameter int HOLD = 6
)
(
  input wire logic clock,
  output logic external_reset_n,
  output logic external_reset_n_driven
);
  //////////////////////////////////////////////////
  // low until supply settles
  initial
  begin
    external_reset_n = 1'b0;
    external_reset_n_driven = 1'b1;
    repeat (HOLD) @(posedge clock);
    release_line();
  end
  task automatic release_line();
    external_reset_n_driven <= 1'b0;
    external_reset_n <= 1'b1;
  endtask
  task automatic pulse(input int n);
    external_reset_n_driven <= 1'b1;
    external_reset_n <= 1'b0;
    repeat (n) @(posedge clock);
    release_line();
  endtask
endmodule
